//--- hdl/pfrs_pkg.sv
// pfrs_pkg: shared constants for the power-fail and reset sequencer.
// assumes a 100 MHz system clock; the 32.768 kHz time base is an enable.
package pfrs_pkg;

  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned OSC_HZ = 32_768;
  // system clocks per time-base tick, rounded up (times come out long)
  localparam int unsigned TICK_DIV_CYC = (CLK_HZ + OSC_HZ - 1) / OSC_HZ;

  localparam int unsigned CNT_W = 13;

  // times as printed, in milliseconds
  localparam int unsigned RST_DELAY_SHORT_MS = 9;
  localparam int unsigned RST_DELAY_LONG_MS = 18;
  localparam int unsigned RST_HOLD_SHORT_MS = 95;
  localparam int unsigned RST_HOLD_LONG_MS = 190;
  localparam int unsigned DEBOUNCE_MS = 5;

  // least times in time-base ticks, rounded up
  localparam int unsigned RST_DELAY_SHORT_TK =
    (RST_DELAY_SHORT_MS * OSC_HZ + 999) / 1000;
  localparam int unsigned RST_DELAY_LONG_TK =
    (RST_DELAY_LONG_MS * OSC_HZ + 999) / 1000;
  localparam int unsigned RST_HOLD_SHORT_TK =
    (RST_HOLD_SHORT_MS * OSC_HZ + 999) / 1000;
  localparam int unsigned RST_HOLD_LONG_TK =
    (RST_HOLD_LONG_MS * OSC_HZ + 999) / 1000;
  localparam int unsigned DEBOUNCE_TK = (DEBOUNCE_MS * OSC_HZ + 999) / 1000;

  // register map, byte addresses
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam int unsigned CTRL_SWRST_BIT = 0;
  localparam logic CTRL_RESET_VAL = 1'b0;

  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic [2:0] {
    ST_RUN        = 3'h0,
    ST_FAULT_WAIT = 3'h1,
    ST_FAULT_RST  = 3'h2,
    ST_PB_HELD    = 3'h3,
    ST_HOLD       = 3'h4
  } pfrs_state_type;

endpackage

//--- hdl/pfrs_debounce.sv
// pfrs_debounce: time-base sampled debouncer for an active-low button.
// assumes tick is a one-cycle enable from the time-base divider.
`timescale 1ns/1ns
`default_nettype none
module pfrs_debounce #(
  parameter int unsigned CNT_W = 13,
  parameter logic [12:0] STABLE_TICKS = 13'h00a4
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic tick,
  input wire logic raw_n,
  output logic pressed
);

  logic pressed_q;
  logic [CNT_W-1:0] stable_q;

  assign pressed = pressed_q;

  // the level must differ from the accepted one for a whole stable run
  // before it is taken, in both directions, so contact bounce is ignored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pressed_q <= 1'b0;
      stable_q <= '0;
    end else if ((!raw_n) == pressed_q) begin
      stable_q <= '0;
    end else if (tick) begin
      if (stable_q == STABLE_TICKS[CNT_W-1:0] - 1'b1) begin // RULE18
        pressed_q <= !raw_n; // RULE10
        stable_q <= '0;
      end else begin
        stable_q <= stable_q + 1'b1;
      end
    end
  end

endmodule // pfrs_debounce
`default_nettype wire

//--- hdl/pfrs_top.sv
// pfrs_top: power-fail and reset sequencer with an AHB-Lite register slave.
// assumes comparator results arrive as synchronous levels on hclk and that
// hresetn stands for the power-up of the device.
`timescale 1ns/1ns
`default_nettype none
//
// Contract
// [RULE1] supply fault asserts both power-fail outputs without added delay
// [RULE2] reset asserts after fault lasts 9 ms (strap low) or 18 ms (high)
// [RULE3] reset and power-fail stay asserted while supply stays bad
// [RULE4] a fault shorter than the delay never asserts reset
// [RULE5] power-fail clears at once when supply returns
// [RULE6] reset held 95 ms (strap low) or 190 ms (high) after recovery
// [RULE7] tolerance select picks 5 percent (low) or 10 percent (high) band
// [RULE8] reset, power-fail, low-battery driven as opposite pairs; both low-battery outputs are driven low during a fault
// [RULE9] other party requests manual reset by pulling pushbutton low
// [RULE10] pushbutton is debounced before starting a manual reset
// [RULE11] pushbutton reset lasts at least 95 ms or 190 ms by strap
// [RULE12] pushbutton hold timer starts on debounced release
// [RULE13] battery is judged only while main supply is good
// [RULE14] low battery stays asserted until battery recovers or supply fails
// [RULE15] low battery asserted before reset is released on power-up
// [RULE16] both low-battery outputs low while supply is bad
// [RULE17] all timing counted from the 32.768 kHz time base
// [RULE18] button changes accepted only after a stable run of ticks
// [RULE19] new fault or press during hold keeps reset and restarts timing
module pfrs_top
  import pfrs_pkg::*;
#(
  parameter logic [12:0] TICK_DIV = 13'(TICK_DIV_CYC),
  parameter logic [12:0] DELAY_SHORT = 13'(RST_DELAY_SHORT_TK),
  parameter logic [12:0] DELAY_LONG = 13'(RST_DELAY_LONG_TK),
  parameter logic [12:0] HOLD_SHORT = 13'(RST_HOLD_SHORT_TK),
  parameter logic [12:0] HOLD_LONG = 13'(RST_HOLD_LONG_TK),
  parameter logic [12:0] DEBOUNCE = 13'(DEBOUNCE_TK)
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic vcc_below_5pct,
  input wire logic vcc_below_10pct,
  input wire logic battery_low,
  input wire logic tolerance_select,
  input wire logic duration_select,
  input wire logic pushbutton_reset_n,
  output logic reset_out,
  output logic reset_out_n,
  output logic power_fail_out,
  output logic power_fail_out_n,
  output logic low_battery_out,
  output logic low_battery_out_n
);
  import pfrs_pkg::*;

  pfrs_state_type state_q, state_d;
  logic [CNT_W-1:0] div_q;
  logic tick;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] delay_lim, hold_lim;
  logic fault, pb_pressed, press;
  logic ctrl_swrst_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic addr_phase;
  logic rst_d, rst_q, rst_n_q, pf_q, pf_n_q, lb_q, lb_n_q;
  logic [31:0] rdata_q;
  logic cnt_done_delay, cnt_done_hold;

  // time base: one-cycle enable at the crystal rate
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_q <= '0;
    end else if (div_q == TICK_DIV - 1'b1) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end
  assign tick = (div_q == TICK_DIV - 1'b1); // RULE17

  // threshold choice and strap-selected durations
  assign fault = tolerance_select ? vcc_below_10pct : vcc_below_5pct; // RULE7
  assign delay_lim = duration_select ? DELAY_LONG : DELAY_SHORT; // RULE2
  assign hold_lim = duration_select ? HOLD_LONG : HOLD_SHORT; // RULE6

  pfrs_debounce #(
    .CNT_W(CNT_W),
    .STABLE_TICKS(DEBOUNCE)
  ) u_debounce (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(tick),
    .raw_n(pushbutton_reset_n), // RULE9
    .pressed(pb_pressed)
  );

  // software request behaves as a held button, debounce not needed
  assign press = pb_pressed || ctrl_swrst_q; // RULE10

  assign cnt_done_delay = tick && (cnt_q == delay_lim - 1'b1);
  assign cnt_done_hold = tick && (cnt_q == hold_lim - 1'b1);

  // sequencing
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (fault) begin
          state_d = ST_FAULT_WAIT;
        end else if (press) begin
          state_d = ST_PB_HELD;
        end
      end
      ST_FAULT_WAIT: begin
        if (!fault) begin
          state_d = ST_RUN; // RULE4
        end else if (cnt_done_delay) begin
          state_d = ST_FAULT_RST; // RULE2
        end
      end
      ST_FAULT_RST: begin
        if (!fault) begin
          state_d = ST_HOLD; // RULE6
        end
      end
      ST_PB_HELD: begin
        if (fault) begin
          state_d = ST_FAULT_RST; // RULE19
        end else if (!press) begin
          state_d = ST_HOLD; // RULE12
        end
      end
      ST_HOLD: begin
        if (fault) begin
          state_d = ST_FAULT_RST; // RULE19
        end else if (press) begin
          state_d = ST_PB_HELD; // RULE19
        end else if (cnt_done_hold) begin
          state_d = ST_RUN; // RULE11
        end
      end
      default: begin
        state_d = ST_HOLD;
      end
    endcase
  end

  // power-up counts as a recovery, so the first release waits a full hold
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= ST_HOLD;
    end else begin
      state_q <= state_d;
    end
  end

  // one counter serves both intervals; it restarts on every state change
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= '0;
    end else if (state_d != state_q) begin
      cnt_q <= '0;
    end else if (tick) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign rst_d = (state_d == ST_FAULT_RST) || (state_d == ST_PB_HELD) ||
                 (state_d == ST_HOLD);

  // outputs: the only added latency is the output flop itself; each half
  // of a pair has its own flop so no output passes through a gate
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rst_q <= 1'b1;
      rst_n_q <= 1'b0;
      pf_q <= 1'b0;
      pf_n_q <= 1'b1;
      lb_q <= 1'b0;
      lb_n_q <= 1'b1;
    end else begin
      rst_q <= rst_d; // RULE3
      rst_n_q <= !rst_d; // RULE8
      pf_q <= fault; // RULE1 RULE5
      pf_n_q <= !fault; // RULE8
      // battery judged every cycle the supply is good, so it is valid
      // long before the hold interval can end
      lb_q <= !fault && battery_low; // RULE13 RULE14 RULE15
      lb_n_q <= !fault && !battery_low; // RULE16
    end
  end

  assign reset_out = rst_q;
  assign reset_out_n = rst_n_q; // RULE8
  assign power_fail_out = pf_q;
  assign power_fail_out_n = pf_n_q; // RULE8
  assign low_battery_out = lb_q;
  assign low_battery_out_n = lb_n_q;

  // AHB-Lite slave, zero wait states, always OKAY
  assign addr_phase = hsel && hready && (htrans != HTRANS_IDLE) &&
                      (htrans[1] == 1'b1);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else if (hready) begin
      wr_pend_q <= addr_phase && hwrite;
      wr_addr_q <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_swrst_q <= CTRL_RESET_VAL;
    end else if (wr_pend_q && (wr_addr_q == CTRL_ADDR)) begin
      ctrl_swrst_q <= hwdata[CTRL_SWRST_BIT];
    end
  end

  // read data is latched in the address phase so it stands all data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (addr_phase && !hwrite) begin
      if (haddr[31:8] != 24'h00_0000) begin
        rdata_q <= 32'h0000_0000;
      end else if (haddr[7:0] == CTRL_ADDR) begin
        rdata_q <= {31'h0000_0000, ctrl_swrst_q};
      end else if (haddr[7:0] == STATUS_ADDR) begin
        rdata_q <= {24'h00_0000, 1'b0, state_q, pb_pressed, lb_q, pf_q,
                    rst_q};
      end else begin
        rdata_q <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp <= HRESP_OKAY;
    end
  end
  assign hrdata = rdata_q;

  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_fault_expires;
    state_q == ST_FAULT_WAIT && fault && cnt_done_delay;
  endsequence
  sequence s_reset_asserted;
    state_q == ST_FAULT_RST ##1 reset_out && !reset_out_n;
  endsequence
  sequence s_hold_expires;
    state_q == ST_HOLD && !fault && !press && cnt_done_hold;
  endsequence
  // reset follows the state at the same edge, so a press right after the
  // release may legally raise it again one cycle later
  sequence s_released;
    state_q == ST_RUN && !reset_out && reset_out_n;
  endsequence

  property p_pf_at_once;
    fault |=> power_fail_out && !power_fail_out_n;
  endproperty
  a_pf_at_once: assert property (p_pf_at_once) // RULE1
    else $error("power-fail not asserted one cycle after fault");

  property p_reset_after_delay;
    s_fault_expires |=> s_reset_asserted;
  endproperty
  a_reset_after_delay: assert property (p_reset_after_delay) // RULE2
    else $error("reset not asserted when fault delay expired");

  property p_stay_while_bad;
    (reset_out && fault) |=> reset_out && power_fail_out;
  endproperty
  a_stay_while_bad: assert property (p_stay_while_bad) // RULE3
    else $error("reset or power-fail dropped while supply bad");

  property p_short_fault;
    (state_q == ST_FAULT_WAIT && !fault) |=> state_q == ST_RUN ##1
      !reset_out;
  endproperty
  a_short_fault: assert property (p_short_fault) // RULE4
    else $error("reset asserted for a short fault");

  property p_pf_clears;
    (!fault && power_fail_out) |=> !power_fail_out && power_fail_out_n;
  endproperty
  a_pf_clears: assert property (p_pf_clears) // RULE5
    else $error("power-fail not cleared on recovery");

  property p_hold_release;
    s_hold_expires |=> s_released;
  endproperty
  a_hold_release: assert property (p_hold_release) // RULE6
    else $error("reset not released at end of hold");

  property p_no_early_release;
    (state_q == ST_HOLD && !cnt_done_hold) |=> state_q != ST_RUN;
  endproperty
  a_no_early_release: assert property (p_no_early_release) // RULE11
    else $error("reset released before hold expired");

  property p_pairs;
    reset_out != reset_out_n && power_fail_out != power_fail_out_n;
  endproperty
  a_pairs: assert property (p_pairs) // RULE8
    else $error("complementary outputs not opposite");

  property p_release_starts_hold;
    (state_q == ST_PB_HELD && !press && !fault) |=>
      state_q == ST_HOLD && cnt_q == '0;
  endproperty
  a_release_starts_hold: assert property (p_release_starts_hold) // RULE12
    else $error("hold not restarted on button release");

  property p_lb_low_batt;
    (!fault && battery_low) |=> low_battery_out && !low_battery_out_n;
  endproperty
  a_lb_low_batt: assert property (p_lb_low_batt) // RULE14
    else $error("low battery not reported");

  property p_lb_both_low;
    fault |=> !low_battery_out && !low_battery_out_n;
  endproperty
  a_lb_both_low: assert property (p_lb_both_low) // RULE16
    else $error("low-battery outputs not both low in fault");

  property p_restart_on_fault;
    (state_q == ST_HOLD && fault) |=> state_q == ST_FAULT_RST && reset_out;
  endproperty
  a_restart_on_fault: assert property (p_restart_on_fault) // RULE19
    else $error("fault during hold did not restart timing");

endmodule // pfrs_top
`default_nettype wire

//--- tb/pfrs_board.sv
// pfrs_board: board side of the sequencer, a contact button and the cpu.
// assumes it shares hclk with the bench; the button idles high (pull-up).
`timescale 1ns/1ns
`default_nettype none
module pfrs_board (
  input wire logic hclk,
  input wire logic reset_out_n,
  output logic pushbutton_reset_n,
  output logic [7:0] pulse_cnt
);
  logic rst_n_q;
  initial begin
    pushbutton_reset_n = 1'b1;
    pulse_cnt = 8'h00;
    rst_n_q = 1'b1;
  end
  // the cpu counts every reset pulse it is handed
  always @(posedge hclk) begin
    rst_n_q <= reset_out_n;
    if (rst_n_q === 1'b1 && reset_out_n === 1'b0)
      pulse_cnt <= pulse_cnt + 8'h01;
  end
  // contact bounce: n short openings before the closure settles
  task automatic push(input int n);
    repeat (n) begin
      @(posedge hclk) pushbutton_reset_n <= 1'b0;
      @(posedge hclk) pushbutton_reset_n <= 1'b1;
    end
    @(posedge hclk) pushbutton_reset_n <= 1'b0;
  endtask
  task automatic let_go(input int n);
    repeat (n) begin
      @(posedge hclk) pushbutton_reset_n <= 1'b1;
      @(posedge hclk) pushbutton_reset_n <= 1'b0;
    end
    @(posedge hclk) pushbutton_reset_n <= 1'b1;
  endtask
endmodule // pfrs_board
`default_nettype wire

//--- tb/pfrs_top_tb.sv
// pfrs_top_tb: self-checking bench for the power-fail and reset sequencer.
// assumes two clocks per tick and a short debounce; delays and holds as built.
`timescale 1ns/1ns
`default_nettype none
module pfrs_top_tb;
  import pfrs_pkg::*;
  localparam int T = 2;
  localparam int DS = int'(RST_DELAY_SHORT_TK);
  localparam int DL = int'(RST_DELAY_LONG_TK);
  localparam int HS = int'(RST_HOLD_SHORT_TK);
  localparam int HL = int'(RST_HOLD_LONG_TK);
  localparam int DB = 2;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic below5, below10, battery_low, tolerance_select, duration_select;
  logic pb_n, reset_out, reset_out_n, power_fail_out, power_fail_out_n;
  logic low_battery_out, low_battery_out_n;
  logic [7:0] pulse_cnt;
  int error_cnt, n_checks;
  assign hready = hreadyout;
  // only the time base and the debounce are shortened
  pfrs_top #(
    .TICK_DIV(13'(T)),
    .DEBOUNCE(13'(DB))
  ) i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .vcc_below_5pct(below5), .vcc_below_10pct(below10),
    .battery_low(battery_low), .tolerance_select(tolerance_select),
    .duration_select(duration_select), .pushbutton_reset_n(pb_n),
    .reset_out(reset_out), .reset_out_n(reset_out_n),
    .power_fail_out(power_fail_out), .power_fail_out_n(power_fail_out_n),
    .low_battery_out(low_battery_out), .low_battery_out_n(low_battery_out_n)
  );
  pfrs_board i_board (
    .hclk(hclk), .reset_out_n(reset_out_n),
    .pushbutton_reset_n(pb_n), .pulse_cnt(pulse_cnt)
  );
  always #5 hclk = ~hclk;

  function automatic bit ck(input bit ok);
    n_checks++;
    return !ok;
  endfunction
  function automatic bit opp(input logic a, input logic b);
    return (a === 1'b1 && b === 1'b0) || (a === 1'b0 && b === 1'b1);
  endfunction
  task automatic err(input string m);
    error_cnt++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // counts falling clock edges until reset_out reaches v
  task automatic wait_rst(input logic v, input int lo, input int hi,
                          input string m);
    int n;
    n = 0;
    do begin
      @(negedge hclk);
      n++;
    end while (reset_out !== v && n <= hi);
    if (ck(n >= lo && n <= hi)) err(m);
  endtask
  task automatic ahb(input logic wr, input logic [31:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= HTRANS_IDLE;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
    if (ck(hresp === HRESP_OKAY)) err("bus response not okay");
    hsel <= 1'b0;
  endtask

  // pairs must stay opposite; low battery is exempt while power-fail is up
  always @(negedge hclk) begin
    if (hresetn === 1'b1) begin
      if (ck(opp(reset_out, reset_out_n) &&
             opp(power_fail_out, power_fail_out_n)))
        err("output pair not opposite");
      if (power_fail_out === 1'b0 &&
          ck(opp(low_battery_out, low_battery_out_n)))
        err("low battery pair not opposite");
    end
  end

  task automatic t_powerup;
    @(negedge hclk);
    if (ck(reset_out === 1'b1)) err("no power-up reset");
    wait_rst(1'b0, (HS-1)*T, HS*T+6,
             "power-up reset length");
    if (ck(low_battery_out === 1'b1)) err("low battery late");
    @(posedge hclk) battery_low <= 1'b0;
  endtask
  task automatic t_regs;
    logic [31:0] d;
    ahb(1'b0, 32'(STATUS_ADDR), 32'h0, d);
    if (ck(d === 32'h0)) err("status not idle");
    ahb(1'b1, 32'(CTRL_ADDR), 32'h1, d);
    ahb(1'b0, 32'(CTRL_ADDR), 32'h0, d);
    if (ck(d === 32'h1)) err("control readback");
    @(negedge hclk);
    if (ck(reset_out === 1'b1)) err("software reset missing");
    ahb(1'b0, 32'(STATUS_ADDR), 32'h0, d);
    if (ck(d[1:0] === 2'h1)) err("status flags");
    ahb(1'b1, 32'(CTRL_ADDR), 32'h0, d);
    wait_rst(1'b0, (HS-1)*T-2, (HS+1)*T+6, "software hold");
    ahb(1'b1, 32'h8, 32'hffff_ffff, d);
    ahb(1'b0, 32'h8, 32'h0, d);
    if (ck(d === 32'h0)) err("unmapped read not zero");
    ahb(1'b0, 32'(CTRL_ADDR), 32'h0, d);
    if (ck(d === 32'h0)) err("control disturbed");
  endtask
  task automatic t_glitch;
    logic [7:0] p;
    p = pulse_cnt;
    @(posedge hclk) battery_low <= 1'b1;
    repeat (2) @(negedge hclk);
    if (ck(low_battery_out === 1'b1)) err("low battery missed");
    @(posedge hclk) below5 <= 1'b1;
    @(posedge hclk);
    @(negedge hclk);
    if (ck(power_fail_out === 1'b1)) err("power-fail late");
    if (ck(low_battery_out === 1'b0 &&
           low_battery_out_n === 1'b0))
      err("low battery pair not low");
    @(posedge hclk) below5 <= 1'b0;
    @(posedge hclk);
    @(negedge hclk);
    if (ck(power_fail_out === 1'b0)) err("power-fail stuck");
    repeat (DS*T+8) @(negedge hclk);
    if (ck(reset_out === 1'b0 && pulse_cnt === p))
      err("short fault reset");
    if (ck(low_battery_out === 1'b1)) err("low battery lost");
    @(posedge hclk) battery_low <= 1'b0;
    repeat (2) @(negedge hclk);
    if (ck(low_battery_out === 1'b0)) err("low battery stuck");
  endtask
  task automatic t_tol;
    @(posedge hclk);
    tolerance_select <= 1'b1;
    below5 <= 1'b1;
    repeat (3) @(negedge hclk);
    if (ck(power_fail_out === 1'b0)) err("wide band tripped early");
    @(posedge hclk) below10 <= 1'b1;
    @(posedge hclk);
    @(negedge hclk);
    if (ck(power_fail_out === 1'b1)) err("wide band missed");
    @(posedge hclk);
    below5 <= 1'b0;
    tolerance_select <= 1'b0;
    repeat (3) @(negedge hclk);
    if (ck(power_fail_out === 1'b0)) err("narrow band used wide");
    @(posedge hclk) below10 <= 1'b0;
  endtask
  task automatic t_fault(input logic strap);
    int d, h;
    d = strap ? DL : DS;
    h = strap ? HL : HS;
    @(posedge hclk);
    duration_select <= strap;
    below5 <= 1'b1;
    @(posedge hclk);
    @(negedge hclk);
    if (ck(power_fail_out === 1'b1)) err("power-fail late");
    wait_rst(1'b1, (d-1)*T, d*T+4, "reset delay");
    repeat (3*T) @(negedge hclk);
    if (ck(reset_out === 1'b1 && power_fail_out === 1'b1))
      err("not held in fault");
    @(posedge hclk) below5 <= 1'b0;
    @(posedge hclk);
    @(negedge hclk);
    if (ck(power_fail_out === 1'b0 && reset_out === 1'b1))
      err("recovery order");
    // a second short fault in the hold keeps reset and restarts the hold
    repeat (2*T) @(negedge hclk);
    @(posedge hclk) below5 <= 1'b1;
    @(posedge hclk);
    @(posedge hclk) below5 <= 1'b0;
    @(posedge hclk);
    @(negedge hclk);
    if (ck(reset_out === 1'b1 && power_fail_out === 1'b0))
      err("fault in hold dropped reset");
    wait_rst(1'b0, (h-1)*T-1, h*T+4, "reset hold");
  endtask
  task automatic t_button;
    i_board.push(0);
    i_board.let_go(0);
    repeat (12) @(negedge hclk);
    if (ck(reset_out === 1'b0)) err("bounce taken as press");
    i_board.push(3);
    wait_rst(1'b1, (DB-1)*T, (DB+1)*T+6, "press debounce");
    repeat (40) @(posedge hclk);
    i_board.let_go(3);
    repeat (8) @(negedge hclk);
    i_board.push(0);
    repeat (10) @(posedge hclk);
    i_board.let_go(0);
    wait_rst(1'b0, (HS-1)*T, (HS+DB+1)*T+6,
             "press hold");
  endtask

  // the run takes about forty thousand clocks; this allows twice that
  initial begin
    #800000;
    err("watchdog expired");
    print_verdict();
  end
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = HTRANS_IDLE;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    below5 = 1'b0;
    below10 = 1'b0;
    battery_low = 1'b1;
    tolerance_select = 1'b0;
    duration_select = 1'b0;
    error_cnt = 0;
    n_checks = 0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    t_powerup();
    t_regs();
    t_glitch();
    t_tol();
    t_fault(1'b0);
    t_fault(1'b1);
    @(posedge hclk) duration_select <= 1'b0;
    t_button();
    print_verdict();
  end
endmodule // pfrs_top_tb
`default_nettype wire
